// ---- include/pot_cfg.svh ----
// register indices, field positions, reset values and timing counts of the overflow timer
`ifndef POT_CFG_SVH
`define POT_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define POT_IDX_CTL      8'h05
`define POT_IDX_LO       8'h0B
`define POT_IDX_HI       8'h0C
`define POT_IDX_STAT     8'h10
`define POT_IDX_MASK     8'h11

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define POT_CTL_IRQ_EDGE 7
`define POT_CTL_CNT_EDGE 6
`define POT_CTL_SRC      5
`define POT_CTL_PS_HI    4
`define POT_CTL_PS_LO    1
`define POT_CTL_RST      8'h00

// ----------------------------------------------------------------
// status and mask fields
// ----------------------------------------------------------------
`define POT_ST_OVF       0
`define POT_ST_EXT       1
`define POT_ST_W         2

// ----------------------------------------------------------------
// axi answers
// ----------------------------------------------------------------
`define POT_RESP_OKAY    2'h0
`define POT_RESP_SLVERR  2'h2

// ----------------------------------------------------------------
// timing: core clock and instruction clock (core divided by four)
// ----------------------------------------------------------------
`define POT_CLK_NS       5
`define POT_TCY_NS       20
`define POT_TCY_CYC      (`POT_TCY_NS / `POT_CLK_NS)

`endif

// ---- include/pot_pkg.sv ----
// types shared by the overflow timer design
package pot_pkg;

    // register selected by a bus address
    typedef enum {
        POT_SEL_CTL,
        POT_SEL_LO,
        POT_SEL_HI,
        POT_SEL_STAT,
        POT_SEL_MASK,
        POT_SEL_NONE
    } pot_sel_t;

    typedef logic [7:0] pot_byte_t;

endpackage : pot_pkg

// ---- src/pot_prescaler.sv ----
// programmable prescaler counter with ratio decode
`timescale 1ns/1ps

module pot_prescaler
    import pot_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire logic         src_tick,
    input  wire logic [3:0]   ps_sel,
    output logic      [W-1:0] cnt_q,
    output logic              tick
);

    // ----------------------------------------------------------------
    // ratio decode: 0..7 give 2^n, 1xxx gives 2^W
    // ----------------------------------------------------------------
    function automatic logic [W-1:0] ratio_mask(input logic [3:0] code);
        logic [W-1:0] one;
        one = {{(W-1){1'b0}}, 1'b1};
        if (code[3]) begin
            ratio_mask = {W{1'b1}};
        end else begin
            ratio_mask = (one << code[2:0]) - one;
        end
    endfunction : ratio_mask

    // counter cleared by writes to the main counter, else counts source ticks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (src_tick) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // one tick per full ratio of source ticks
    assign tick = src_tick && ((cnt_q & ratio_mask(ps_sel)) == ratio_mask(ps_sel));

endmodule : pot_prescaler

// ---- src/pot_timer16.sv ----
// 16-bit overflow timer with prescaler, axi4-lite registers and interrupt logic
`timescale 1ns/1ps
`include "pot_cfg.svh"

module pot_timer16
    import pot_pkg::*;
#(
    parameter int AW = 12,
    parameter int PW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          ext_count_pin,
    input  wire logic          ext_irq_pin,
    input  wire logic          vector_ack,
    output logic               irq,
    output logic               ovf_irq_req,
    output logic               ext_irq_req
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic pot_sel_t pot_decode(input logic [AW-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'h0)               pot_decode = POT_SEL_NONE;
        else if (idx == `POT_IDX_CTL)     pot_decode = POT_SEL_CTL;
        else if (idx == `POT_IDX_LO)      pot_decode = POT_SEL_LO;
        else if (idx == `POT_IDX_HI)      pot_decode = POT_SEL_HI;
        else if (idx == `POT_IDX_STAT)    pot_decode = POT_SEL_STAT;
        else if (idx == `POT_IDX_MASK)    pot_decode = POT_SEL_MASK;
        else                              pot_decode = POT_SEL_NONE;
    endfunction : pot_decode

    logic [AW-1:0]   awaddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            aw_have_q;
    logic            w_have_q;
    logic            awready_q;
    logic            wready_q;
    logic            bvalid_q;
    logic [1:0]      bresp_q;
    logic            arready_q;
    logic            rvalid_q;
    logic [1:0]      rresp_q;
    logic [31:0]     rdata_q;
    logic            do_write;
    logic            ar_take;
    pot_sel_t        wsel;
    pot_sel_t        rsel;
    logic            wr_ctl;
    logic            wr_lo;
    logic            wr_hi;
    logic            wr_mask;
    logic            rd_stat;
    logic [7:1]      ctl_q;
    pot_byte_t       cnt_lo_q;
    pot_byte_t       cnt_hi_q;
    logic [`POT_ST_W-1:0] status_q;
    logic [`POT_ST_W-1:0] mask_q;
    logic            hold_lo_q;
    logic            hold_hi_q;
    logic [7:0]      ph_q;
    logic            instr_en;
    logic            sample_en;
    logic [1:0]      cnt_sync_q;
    logic [1:0]      irq_sync_q;
    logic            sel_pin_q;
    logic            sel_pin_prev_q;
    logic            irq_pin_prev_q;
    logic            ps_level;
    logic            ps_samp_q;
    logic [PW-1:0]   ps_cnt;
    logic            ps_tick;
    logic            ps_src;
    logic            src_int;
    logic            inc;
    logic            lo_inc;
    logic            hi_inc;
    logic            ovf_evt;
    logic            ext_evt;
    logic            irq_q;
    logic            ovf_req_q;
    logic            ext_req_q;

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign wsel     = pot_decode(awaddr_q);
    assign wr_ctl   = do_write && wstrb_q[0] && (wsel == POT_SEL_CTL);
    assign wr_lo    = do_write && wstrb_q[0] && (wsel == POT_SEL_LO);
    assign wr_hi    = do_write && wstrb_q[0] && (wsel == POT_SEL_HI);
    assign wr_mask  = do_write && wstrb_q[0] && (wsel == POT_SEL_MASK);

    // address and data held separately, taken in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awaddr_q  <= '0;
            aw_have_q <= 1'b0;
            awready_q <= 1'b1;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
            awready_q <= 1'b1;
        end else if (s_axi_awvalid && awready_q) begin
            awaddr_q  <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdata_q  <= '0;
            wstrb_q  <= '0;
            w_have_q <= 1'b0;
            wready_q <= 1'b1;
        end else if (do_write) begin
            w_have_q <= 1'b0;
            wready_q <= 1'b1;
        end else if (s_axi_wvalid && wready_q) begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
        end
    end

    // write response, unmapped addresses answer slverr
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `POT_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == POT_SEL_NONE) ? `POT_RESP_SLVERR : `POT_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    assign ar_take = s_axi_arvalid && arready_q;
    assign rsel    = pot_decode(s_axi_araddr);
    assign rd_stat = ar_take && (rsel == POT_SEL_STAT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `POT_RESP_OKAY;
            rdata_q   <= '0;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= (rsel == POT_SEL_NONE) ? `POT_RESP_SLVERR : `POT_RESP_OKAY;
            case (rsel)
                POT_SEL_CTL:  rdata_q <= {24'h000000, ctl_q, 1'b0};
                POT_SEL_LO:   rdata_q <= {24'h000000, cnt_lo_q};
                POT_SEL_HI:   rdata_q <= {24'h000000, cnt_hi_q};
                POT_SEL_STAT: rdata_q <= {30'h00000000, status_q};
                POT_SEL_MASK: rdata_q <= {30'h00000000, mask_q};
                default:      rdata_q <= 32'h00000000;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // control and mask registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_q <= 7'(`POT_CTL_RST >> 1);
        end else if (wr_ctl) begin
            ctl_q <= wdata_q[7:1]; // bit 0 not stored
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= '0;
        end else if (wr_mask) begin
            mask_q <= wdata_q[`POT_ST_W-1:0];
        end
    end

    assign src_int = ctl_q[`POT_CTL_SRC];

    // ----------------------------------------------------------------
    // instruction clock divider and the two sample points per cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_q <= 8'h00;
        end else if (instr_en) begin
            ph_q <= 8'h00;
        end else begin
            ph_q <= ph_q + 8'h01;
        end
    end

    assign instr_en  = (ph_q == 8'(`POT_TCY_CYC - 1));
    assign sample_en = (ph_q == 8'h00) || (ph_q == 8'(`POT_TCY_CYC / 2));

    // ----------------------------------------------------------------
    // pin synchronisers and edge selection
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_sync_q     <= 2'h0;
            irq_sync_q     <= 2'h0;
            sel_pin_q      <= 1'b1; // idle low pin, falling select: no edge after reset
            sel_pin_prev_q <= 1'b1;
            irq_pin_prev_q <= 1'b0;
        end else begin
            cnt_sync_q     <= {cnt_sync_q[0], ext_count_pin};
            irq_sync_q     <= {irq_sync_q[0], ext_irq_pin};
            sel_pin_q      <= cnt_sync_q[1] ~^ ctl_q[`POT_CTL_CNT_EDGE];
            sel_pin_prev_q <= sel_pin_q;
            irq_pin_prev_q <= irq_sync_q[1];
        end
    end

    // chosen edge of the interrupt pin
    assign ext_evt = ctl_q[`POT_CTL_IRQ_EDGE] ? (irq_sync_q[1] && !irq_pin_prev_q)
                                              : (!irq_sync_q[1] && irq_pin_prev_q);

    // ----------------------------------------------------------------
    // prescaler and increment source
    // ----------------------------------------------------------------
    assign ps_src = src_int ? instr_en : (sel_pin_q && !sel_pin_prev_q);

    pot_prescaler #(
        .W        (PW)
    ) u_prescaler (
        .clk      (clk),
        .rst      (rst),
        .clear    (wr_lo || wr_hi),
        .src_tick (ps_src),
        .ps_sel   (ctl_q[`POT_CTL_PS_HI:`POT_CTL_PS_LO]),
        .cnt_q    (ps_cnt),
        .tick     (ps_tick)
    );

    // prescaler output level: pin itself at 1:1, else the ratio bit
    always_comb begin
        if (ctl_q[4:1] == 4'h0) begin
            ps_level = sel_pin_q;
        end else if (ctl_q[4]) begin
            ps_level = ps_cnt[PW-1];
        end else begin
            ps_level = ps_cnt[3'(ctl_q[3:1] - 3'h1)];
        end
    end

    // output sampled at both sample points, rising change increments
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ps_samp_q <= 1'b1; // matches the idle 1:1 level, so no false count
        end else if (sample_en) begin
            ps_samp_q <= ps_level;
        end
    end

    assign inc = src_int ? ps_tick : (sample_en && ps_level && !ps_samp_q);

    // ----------------------------------------------------------------
    // main counter with write hold
    // ----------------------------------------------------------------
    assign lo_inc  = inc && !hold_lo_q;
    assign hi_inc  = lo_inc && (cnt_lo_q == 8'hFF) && !hold_hi_q;
    assign ovf_evt = hi_inc && (cnt_hi_q == 8'hFF) && !wr_lo && !wr_hi;

    // hold lasts until the next instruction boundary
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_lo_q <= 1'b0;
            hold_hi_q <= 1'b0;
        end else begin
            hold_lo_q <= wr_lo || (hold_lo_q && !instr_en);
            hold_hi_q <= wr_hi || (hold_hi_q && !instr_en);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_lo_q <= 8'h00;
        end else if (wr_lo) begin
            cnt_lo_q <= wdata_q[7:0];
        end else if (lo_inc) begin
            cnt_lo_q <= cnt_lo_q + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_hi_q <= 8'h00;
        end else if (wr_hi) begin
            cnt_hi_q <= wdata_q[7:0];
        end else if (hi_inc) begin
            cnt_hi_q <= cnt_hi_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // sticky status, cleared by read (overflow flag also by vectoring); set wins
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q[`POT_ST_OVF] <= ovf_evt ||
                (status_q[`POT_ST_OVF] && !rd_stat && !vector_ack);
            status_q[`POT_ST_EXT] <= ext_evt || (status_q[`POT_ST_EXT] && !rd_stat);
        end
    end

    // requests gated by the enable bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q     <= 1'b0;
            ovf_req_q <= 1'b0;
            ext_req_q <= 1'b0;
        end else begin
            irq_q     <= |(status_q & mask_q);
            ovf_req_q <= status_q[`POT_ST_OVF] && mask_q[`POT_ST_OVF];
            ext_req_q <= status_q[`POT_ST_EXT] && mask_q[`POT_ST_EXT];
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign irq           = irq_q;
    assign ovf_irq_req   = ovf_req_q;
    assign ext_irq_req   = ext_req_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic rd_ctl_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rd_ctl_q <= 1'b0;
        else if (ar_take) rd_ctl_q <= (rsel == POT_SEL_CTL);
    end

    a_ovf_sets_flag: assert property (ovf_evt |=> status_q[`POT_ST_OVF])
        else $error("overflow did not set flag");
    a_wrap_to_zero: assert property (ovf_evt |=> {cnt_hi_q, cnt_lo_q} == 16'h0000)
        else $error("counter did not wrap to zero");
    a_req_masked: assert property (!mask_q[`POT_ST_OVF] |=> !ovf_req_q)
        else $error("masked overflow raised request");
    a_req_needs_both: assert property (ovf_req_q |-> $past(status_q[0]) && $past(mask_q[0]))
        else $error("request without flag and enable");
    a_vector_clears: assert property (vector_ack && !ovf_evt |=> !status_q[`POT_ST_OVF])
        else $error("vectoring did not clear flag");
    a_ctl_bit0_zero: assert property (rvalid_q && rd_ctl_q |-> !s_axi_rdata[0])
        else $error("control bit zero read as one");
    a_write_clears_ps: assert property (wr_lo || wr_hi |=> ps_cnt == '0)
        else $error("prescaler not cleared by write");
    a_lo_held: assert property (wr_lo |=> cnt_lo_q == $past(wdata_q[7:0]))
        else $error("written low byte incremented at once");
    a_int_rate: assert property (src_int && lo_inc |=> !lo_inc [*3])
        else $error("internal count faster than instruction rate");
    a_ext_only_when_sel: assert property (src_int |-> !(lo_inc && !instr_en))
        else $error("pin edges counted in internal mode");
    a_irq_edge: assert property (ext_evt |=> status_q[`POT_ST_EXT])
        else $error("interrupt pin edge lost");

    c_overflow: cover property (ovf_evt);
    c_ext_count: cover property (!src_int && inc);
    c_irq_raised: cover property (!irq ##1 irq);
    c_vector: cover property (status_q[0] && vector_ack);

endmodule : pot_timer16

// ---- bench/pot_pin_src.sv ----
// partner model: the source of the external count pin and the external interrupt pin
`timescale 1ns/1ps

module pot_pin_src (
    input  wire logic clk,
    output logic      count_pin,
    output logic      irq_pin
);
    // both pins rest low until the bench asks for an edge
    initial begin
        count_pin = 1'b0;
        irq_pin   = 1'b0;
    end
    // a level changes just after a rising edge and is then held
    task automatic set_count(input logic v);
        @(posedge clk);
        count_pin <= v;
    endtask : set_count
    task automatic set_irq(input logic v);
        @(posedge clk);
        irq_pin <= v;
    endtask : set_irq
endmodule : pot_pin_src

// ---- bench/pot_timer16_tb.sv ----
// self-checking bench of the overflow timer
`timescale 1ns/1ps
`include "pot_cfg.svh"

module pot_timer16_tb;
    logic        clk = 1'b0, rst = 1'b1, vack = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, cnt_pin, irq_pin;
    logic        irq, ovf_req, ext_req;
    int          fails = 0, checks = 0, cyc = 0;

    // 200 MHz core clock
    always #2.5 clk = ~clk;

    pot_timer16 u_pot_timer16 (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_count_pin(cnt_pin), .ext_irq_pin(irq_pin), .vector_ack(vack),
        .irq(irq), .ovf_irq_req(ovf_req), .ext_irq_req(ext_req));
    pot_pin_src u_pot_pin_src (.clk(clk), .count_pin(cnt_pin), .irq_pin(irq_pin));

    // ----------------------------------------------------------------
    // comparison, bus cycles and closing report
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_a(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                        input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr_a
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        wr_a({2'h0, idx, 2'h0}, d, 4'hF, er);
    endtask : wr
    task automatic rd_a(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : rd_a
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        rd_a({2'h0, idx, 2'h0}, d, r);
    endtask : rd
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, `POT_RESP_OKAY});
    endtask : rchk
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // new control value, let a spurious edge settle, then zero the lower byte
    task automatic ctl_clr(input logic [7:0] c);
        wr(`POT_IDX_CTL, c, `POT_RESP_OKAY);
        repeat (12) @(posedge clk);
        wr(`POT_IDX_LO, 8'h00, `POT_RESP_OKAY);
    endtask : ctl_clr
    task automatic ovf_run();
        wr(`POT_IDX_LO, 8'hF0, `POT_RESP_OKAY);
        wr(`POT_IDX_HI, 8'hFF, `POT_RESP_OKAY);
        repeat (100) @(posedge clk);
    endtask : ovf_run

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rchk(`POT_IDX_CTL, 32'h0);
        rchk(`POT_IDX_LO, 32'h0);
        rchk(`POT_IDX_HI, 32'h0);
        rd(8'h3F, d, r);
        chk({30'h0, r}, {30'h0, `POT_RESP_SLVERR});
        wr(8'h3F, 8'h00, `POT_RESP_SLVERR);
        rd_a(12'h02D, d, r);
        chk({30'h0, r}, {30'h0, `POT_RESP_SLVERR});
        wr_a(12'h016, 8'h01, 4'hF, `POT_RESP_SLVERR);
        wr_a({2'h0, `POT_IDX_MASK, 2'h0}, 8'h03, 4'hE, `POT_RESP_OKAY);
        rchk(`POT_IDX_MASK, 32'h0);
        wr(`POT_IDX_CTL, 8'hFF, `POT_RESP_OKAY);
        rchk(`POT_IDX_CTL, 32'hFE);
    endtask : t_regs
    task automatic t_ovf();
        logic [31:0] d;
        logic [1:0]  r;
        wr(`POT_IDX_CTL, 8'h20, `POT_RESP_OKAY);
        rd(`POT_IDX_STAT, d, r);
        ovf_run();
        chk({31'h0, irq}, 32'h0);
        rchk(`POT_IDX_HI, 32'h0);
        rchk(`POT_IDX_STAT, 32'h1);
        wr(`POT_IDX_MASK, 8'h01, `POT_RESP_OKAY);
        ovf_run();
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, ovf_req}, 32'h1);
        vack <= 1'b1;
        @(posedge clk);
        vack <= 1'b0;
        repeat (3) @(posedge clk);
        chk({30'h0, ovf_req, irq}, 32'h0);
        wr(`POT_IDX_MASK, 8'h00, `POT_RESP_OKAY);
    endtask : t_ovf
    task automatic t_ps();
        logic [31:0] d;
        logic [1:0]  r;
        int          ratio;
        for (int c = 0; c < 16; c++) begin
            if (c > 8 && c != 15) continue;
            ratio = c[3] ? 256 : (1 << c[2:0]);
            ctl_clr({3'b001, c[3:0], 1'b0});
            repeat (32 * ratio) @(posedge clk);
            rd(`POT_IDX_LO, d, r);
            chk({31'h0, d >= 7 && d <= 9}, 32'h1);
        end
    endtask : t_ps
    task automatic t_ext();
        ctl_clr(8'h40);
        u_pot_pin_src.set_count(1'b1);
        repeat (12) @(posedge clk);
        rchk(`POT_IDX_LO, 32'h1);
        u_pot_pin_src.set_count(1'b0);
        repeat (12) @(posedge clk);
        rchk(`POT_IDX_LO, 32'h1);
        ctl_clr(8'h00);
        u_pot_pin_src.set_count(1'b1);
        repeat (12) @(posedge clk);
        rchk(`POT_IDX_LO, 32'h0);
        u_pot_pin_src.set_count(1'b0);
        repeat (12) @(posedge clk);
        rchk(`POT_IDX_LO, 32'h1);
    endtask : t_ext
    task automatic t_eirq();
        logic [31:0] d;
        logic [1:0]  r;
        wr(`POT_IDX_CTL, 8'h80, `POT_RESP_OKAY);
        wr(`POT_IDX_MASK, 8'h02, `POT_RESP_OKAY);
        rd(`POT_IDX_STAT, d, r);
        u_pot_pin_src.set_irq(1'b1);
        repeat (10) @(posedge clk);
        chk({30'h0, ext_req, irq}, 32'h3);
        rchk(`POT_IDX_STAT, 32'h2);
        wr(`POT_IDX_CTL, 8'h00, `POT_RESP_OKAY);
        repeat (10) @(posedge clk);
        rd(`POT_IDX_STAT, d, r);
        u_pot_pin_src.set_irq(1'b0);
        repeat (10) @(posedge clk);
        rchk(`POT_IDX_STAT, 32'h2);
        u_pot_pin_src.set_irq(1'b1);
        repeat (10) @(posedge clk);
        rchk(`POT_IDX_STAT, 32'h0);
        wr(`POT_IDX_MASK, 8'h00, `POT_RESP_OKAY);
    endtask : t_eirq

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_ovf();
        t_ps();
        t_ext();
        t_eirq();
        end_sim();
    end
    // cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            end_sim();
        end
    end
endmodule : pot_timer16_tb
